// ### src/icsm_top.sv
// Clock source control: registers, mode selection, oscillator and FLL controls
`include "icsm_regs.svh"

module icsm_top (
  input wire logic CLOCK, // System clock, 25 MHz
  input wire logic RESET_N, // Asynchronous reset, active low
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB access phase
  input wire logic PWRITE, // APB direction
  input wire logic [11:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error on unmapped address
  input wire logic STOP_REQ, // Device in stop, same domain
  input wire logic OSC_INIT_DONE, // Oscillator init cycles done, async pin
  input wire logic EXT_CLK_OK, // External reference running, async pin
  output icsm_pkg::icsm_osc_ctrl_t OSC_CTRL, // Oscillator controls
  output icsm_pkg::icsm_fll_ctrl_t FLL_CTRL, // FLL controls
  output logic [8:0] INT_REF_TRIM, // Internal reference period code
  output logic INT_REF_ENABLE, // Internal reference running
  output logic AUX_INT_CLK_EN, // Internal reference offered as aux clock
  output logic AUX_EXT_CLK_EN, // External reference offered as aux clock
  output logic [1:0] OUT_SRC_SEL, // Applied output clock source
  output logic [1:0] BUS_DIV_SEL, // Bus divider select
  output logic BUS_CLK_EN // Bus clock enable pulse
);
  import icsm_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] ctrl1_r;
  logic [7:0] ctrl2_r;
  logic [7:0] trim_r;
  logic fine_trim_r;
  logic osc_ready_flag_r;
  logic [1:0] mode_meta_r;
  icsm_mode_t clock_mode_status_r;
  logic [1:0] osc_done_sync_r;
  logic [1:0] ext_ok_sync_r;
  logic [1:0] applied_src_r;
  logic [2:0] bus_cnt_r;
  logic [31:0] prdata_r;
  logic stop_ext_mode_r;
  logic stop_d_r;

  logic [1:0] source_select;
  logic [2:0] reference_divider;
  logic fll_reference_select;
  logic int_ref_out_enable;
  logic int_ref_stop_enable;
  logic [1:0] bus_divider;
  logic fll_low_power;
  logic ext_ref_osc_request;
  logic ext_ref_out_enable;
  logic ext_ref_stop_enable;
  logic [1:0] src_req;
  logic [1:0] src_nxt;
  logic ext_mode;
  logic int_mode;
  logic ext_in_use;
  logic wr_acc;
  logic rd_setup;
  logic addr_ok;
  logic osc_ready_flag_nxt;
  logic osc_clr;
  logic [2:0] bus_max;
  logic [7:0] stat_rd;
  logic ctrl2_wr;
  logic req_after;
  logic eren_after;
  logic fll_on;

  // Field views
  assign source_select = ctrl1_r[`ICSM_C1_SRC_HI:`ICSM_C1_SRC_LO];
  assign reference_divider = ctrl1_r[`ICSM_C1_REFERENCE_DIVIDER_HI:`ICSM_C1_REFERENCE_DIVIDER_LO];
  assign fll_reference_select = ctrl1_r[`ICSM_C1_IREF];
  assign int_ref_out_enable = ctrl1_r[`ICSM_C1_IREN];
  assign int_ref_stop_enable = ctrl1_r[`ICSM_C1_ISTEN];
  assign bus_divider = ctrl2_r[`ICSM_C2_BUS_DIVIDER_HI:`ICSM_C2_BUS_DIVIDER_LO];
  assign fll_low_power = ctrl2_r[`ICSM_C2_LP];
  assign ext_ref_osc_request = ctrl2_r[`ICSM_C2_OSCREQ];
  assign ext_ref_out_enable = ctrl2_r[`ICSM_C2_EREN];
  assign ext_ref_stop_enable = ctrl2_r[`ICSM_C2_ESTEN];

  // ****************************************
  // APB slave
  // ****************************************
  assign addr_ok = (PADDR == `ICSM_OFF_CTRL1) || (PADDR == `ICSM_OFF_CTRL2) ||
                   (PADDR == `ICSM_OFF_TRIM) || (PADDR == `ICSM_OFF_STAT);
  assign wr_acc = PSEL && PENABLE && PWRITE && addr_ok;
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;
  assign PRDATA = prdata_r;

  // Status read view, reserved bits read zero
  assign stat_rd = {4'h0, clock_mode_status_r, osc_ready_flag_r, fine_trim_r};

  // Read data captured in the setup phase
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      prdata_r <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (PADDR)
        `ICSM_OFF_CTRL1: prdata_r <= {24'h00_0000, ctrl1_r};
        `ICSM_OFF_CTRL2: prdata_r <= {24'h00_0000, ctrl2_r};
        `ICSM_OFF_TRIM: prdata_r <= {24'h00_0000, trim_r};
        `ICSM_OFF_STAT: prdata_r <= {24'h00_0000, stat_rd};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Control registers, reset to default engaged internal mode
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl1_r <= `ICSM_CTRL1_RST;
      ctrl2_r <= `ICSM_CTRL2_RST;
    end else if (wr_acc) begin
      if (PADDR == `ICSM_OFF_CTRL1) begin
        ctrl1_r <= PWDATA[7:0];
      end
      if (PADDR == `ICSM_OFF_CTRL2) begin
        ctrl2_r <= PWDATA[7:0];
      end
    end
  end

  // Trim storage has no reset so calibration survives
  always_ff @(posedge CLOCK) begin
    if (wr_acc && (PADDR == `ICSM_OFF_TRIM)) begin
      trim_r <= PWDATA[7:0];
    end
    if (wr_acc && (PADDR == `ICSM_OFF_STAT)) begin
      fine_trim_r <= PWDATA[`ICSM_ST_FINE_TRIM];
    end
  end

  // Period code, trim above fine trim, binary weighted
  assign INT_REF_TRIM = {trim_r, fine_trim_r};

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      osc_done_sync_r <= 2'h0;
      ext_ok_sync_r <= 2'h0;
    end else begin
      osc_done_sync_r <= {osc_done_sync_r[0], OSC_INIT_DONE};
      ext_ok_sync_r <= {ext_ok_sync_r[0], EXT_CLK_OK};
    end
  end

  // ****************************************
  // Mode selection
  // ****************************************
  // Reserved source code behaves as FLL
  assign src_req = (source_select == `ICSM_SRC_EXT) ? `ICSM_SRC_EXT :
                   (source_select == `ICSM_SRC_INT) ? `ICSM_SRC_INT : `ICSM_SRC_FLL;

  // External selection waits for a running external clock
  assign src_nxt = ((src_req == `ICSM_SRC_EXT) && !ext_ok_sync_r[1]) ? applied_src_r : src_req;

  // Applied multiplexer selection
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      applied_src_r <= `ICSM_SRC_FLL;
    end else begin
      applied_src_r <= src_nxt;
    end
  end

  // Status follows the applied selection through two stages
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_meta_r <= `ICSM_SRC_FLL;
      clock_mode_status_r <= ICSM_MODE_FLL;
    end else begin
      mode_meta_r <= applied_src_r;
      clock_mode_status_r <= icsm_mode_t'(mode_meta_r);
    end
  end

  // External reference used by the applied mode
  assign ext_mode = (applied_src_r == `ICSM_SRC_EXT) ||
                    ((applied_src_r == `ICSM_SRC_FLL) && !fll_reference_select);
  assign int_mode = !ext_mode;
  assign ext_in_use = ext_ref_out_enable || ext_mode;

  // Remember whether an external mode was in effect at stop entry
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      stop_d_r <= 1'b0;
      stop_ext_mode_r <= 1'b0;
    end else begin
      stop_d_r <= STOP_REQ;
      if (STOP_REQ && !stop_d_r) begin
        stop_ext_mode_r <= ext_mode;
      end
    end
  end

  // ****************************************
  // Oscillator ready flag
  // ****************************************
  // Clear only when out enable or oscillator request is written to zero
  assign ctrl2_wr = wr_acc && (PADDR == `ICSM_OFF_CTRL2);
  assign osc_clr = ctrl2_wr &&
                   ((ext_ref_out_enable && !PWDATA[`ICSM_C2_EREN]) ||
                    (ext_ref_osc_request && !PWDATA[`ICSM_C2_OSCREQ]));

  // Set judged on the values being written, else a clear could never take
  assign req_after = ctrl2_wr ? PWDATA[`ICSM_C2_OSCREQ] : ext_ref_osc_request;
  assign eren_after = ctrl2_wr ? PWDATA[`ICSM_C2_EREN] : ext_ref_out_enable;

  // Set after the clear so a simultaneous set wins
  always_comb begin
    osc_ready_flag_nxt = osc_ready_flag_r;
    if (osc_clr) begin
      osc_ready_flag_nxt = 1'b0;
    end
    if (req_after && (eren_after || ext_mode) && osc_done_sync_r[1]) begin
      osc_ready_flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      osc_ready_flag_r <= 1'b0;
    end else begin
      osc_ready_flag_r <= osc_ready_flag_nxt;
    end
  end

  // ****************************************
  // Reference and FLL controls
  // ****************************************
  // Oscillator range, gain and request straight from the second control register; enable from mode and stop
  always_comb begin
    OSC_CTRL.range_high = ctrl2_r[`ICSM_C2_RANGE];
    OSC_CTRL.high_gain = ctrl2_r[`ICSM_C2_HGO];
    OSC_CTRL.osc_request = ext_ref_osc_request;
    if (STOP_REQ) begin
      OSC_CTRL.enable = ext_ref_stop_enable && (ext_ref_out_enable || stop_ext_mode_r);
    end else begin
      OSC_CTRL.enable = ext_in_use || (fll_on && !fll_reference_select);
    end
  end

  // Aux external clock gated by out enable, and in stop by stop enable
  assign AUX_EXT_CLK_EN = ext_ref_out_enable && (!STOP_REQ || ext_ref_stop_enable);

  // Internal reference on in internal modes or when offered as aux clock; in stop only if stop enable is set
  assign INT_REF_ENABLE = STOP_REQ ? (int_ref_stop_enable && (int_ref_out_enable || !stop_ext_mode_r)) :
                          (int_mode || int_ref_out_enable || (fll_on && fll_reference_select));
  assign AUX_INT_CLK_EN = int_ref_out_enable && (!STOP_REQ || int_ref_stop_enable);

  // FLL off in stop and in low power bypass, locking at 512 times divided reference
  // Running FLL also keeps its chosen reference alive
  assign fll_on = !STOP_REQ &&
                  !((applied_src_r != `ICSM_SRC_FLL) && fll_low_power);

  always_comb begin
    FLL_CTRL.enable = fll_on;
    FLL_CTRL.ref_internal = fll_reference_select;
    FLL_CTRL.ref_div = reference_divider;
    FLL_CTRL.multiplier = `ICSM_FLL_MULT;
  end

  assign OUT_SRC_SEL = applied_src_r;
  assign BUS_DIV_SEL = bus_divider;

  // ****************************************
  // Bus divider
  // ****************************************
  // Terminal count 0, 1, 3 or 7 gives divide by 1, 2, 4 or 8
  assign bus_max = 3'((4'h1 << bus_divider) - 4'h1);

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      bus_cnt_r <= 3'h0;
    end else if (STOP_REQ || bus_cnt_r >= bus_max) begin
      bus_cnt_r <= 3'h0;
    end else begin
      bus_cnt_r <= bus_cnt_r + 3'h1;
    end
  end

  assign BUS_CLK_EN = !STOP_REQ && (bus_cnt_r >= bus_max);

endmodule : icsm_top

// ### src/icsm_regs.svh
// Register offsets, field positions, reset values, FLL multiplier and source codes of the clock source control
//
// Function
// - Bus divider bits 7:6 divide by 1,2,4,8; reset value 01.
// - Bit 5 drives oscillator range: 0 low, 1 high.
// - Bit 4 drives oscillator gain: 0 low power, 1 high gain.
// - Bit 3 set disables the FLL while bypassed; clear keeps it running.
// - Bit 2 requests reference source: 0 external clock, 1 oscillator.
// - Bit 1 gates external reference onto auxiliary clock output.
// - Bit 0 keeps external reference alive in stop if enabled or external mode.
// - Trim field sets reference period, binary weighted, larger value longer.
// - Fine trim set lengthens period one step; clear shortens one step.
// - Status bits 3-2 report applied clock mode, after synchronisation delay.
// - Oscillator ready flag sets when init done, requested and reference used.
// - Oscillator ready flag clears only when out enable or request cleared.
// - Source 00 with internal reference gives engaged internal mode, internal reference on.
// - Engaged FLL locks to 512 times the divided reference.
// - Source 00 with external reference gives engaged external mode.
// - Source 01, internal, low power 0: output internal, FLL keeps locking.
// - Source 01, internal, low power 1: output internal, FLL disabled.
// - External modes keep external reference on; internal modes internal reference.
// - Source select 00 FLL, 01 internal, 10 external, 11 behaves as 00.
// - Reference select: 0 external reference, 1 internal reference for FLL.
// - Reference divider divides by 1 to 128 in powers of two; resets 000.
`ifndef ICSM_REGS_SVH
`define ICSM_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define ICSM_OFF_CTRL1 12'h000
`define ICSM_OFF_CTRL2 12'h004
`define ICSM_OFF_TRIM 12'h008
`define ICSM_OFF_STAT 12'h00C

// ****************************************
// Field positions
// ****************************************
`define ICSM_C1_SRC_HI 7
`define ICSM_C1_SRC_LO 6
`define ICSM_C1_REFERENCE_DIVIDER_HI 5
`define ICSM_C1_REFERENCE_DIVIDER_LO 3
`define ICSM_C1_IREF 2
`define ICSM_C1_IREN 1
`define ICSM_C1_ISTEN 0
`define ICSM_C2_BUS_DIVIDER_HI 7
`define ICSM_C2_BUS_DIVIDER_LO 6
`define ICSM_C2_RANGE 5
`define ICSM_C2_HGO 4
`define ICSM_C2_LP 3
`define ICSM_C2_OSCREQ 2
`define ICSM_C2_EREN 1
`define ICSM_C2_ESTEN 0
`define ICSM_ST_MODE_HI 3
`define ICSM_ST_MODE_LO 2
`define ICSM_ST_OSCRDY 1
`define ICSM_ST_FINE_TRIM 0

// ****************************************
// Reset values and constants
// ****************************************
`define ICSM_CTRL1_RST 8'h04
`define ICSM_CTRL2_RST 8'h40
`define ICSM_FLL_MULT 10'h200
`define ICSM_SRC_FLL 2'h0
`define ICSM_SRC_INT 2'h1
`define ICSM_SRC_EXT 2'h2

`endif

// ### src/icsm_pkg.sv
// Types shared by the clock source control
package icsm_pkg;

  // Applied clock mode, as shown in the status field
  typedef enum logic [1:0] {
    ICSM_MODE_FLL = 2'h0,
    ICSM_MODE_INT = 2'h1,
    ICSM_MODE_EXT = 2'h2,
    ICSM_MODE_RSV = 2'h3
  } icsm_mode_t;

  // Controls presented to the external oscillator
  typedef struct packed {
    logic range_high;
    logic high_gain;
    logic osc_request;
    logic enable;
  } icsm_osc_ctrl_t;

  // Controls presented to the FLL
  typedef struct packed {
    logic enable;
    logic ref_internal;
    logic [2:0] ref_div;
    logic [9:0] multiplier;
  } icsm_fll_ctrl_t;

endpackage : icsm_pkg

// ### test/icsm_osc_model.sv
// External oscillator model: reports readiness a while after it is enabled
module icsm_osc_model #(
  parameter int START_NS = 600 // Start-up time, shorten or lengthen per run
) (
  input wire icsm_pkg::icsm_osc_ctrl_t osc_ctrl, // Controls from the block
  output logic init_done, // Initialisation cycles done
  output logic clk_ok // Reference clock running
);
  timeunit 1ns;
  timeprecision 1ps;
  import icsm_pkg::*;
  // Restart the start-up count once started when enable drops or the request differs from init_done
  initial begin
    init_done = 1'b0;
    clk_ok = 1'b0;
    forever begin
      wait (osc_ctrl.enable === 1'b1);
      #(START_NS);
      if (osc_ctrl.enable === 1'b1) begin
        clk_ok = 1'b1;
        init_done = osc_ctrl.osc_request;
      end
      wait (osc_ctrl.enable !== 1'b1 || osc_ctrl.osc_request !== init_done);
      clk_ok = 1'b0;
      init_done = 1'b0;
    end
  end
endmodule : icsm_osc_model

// ### test/icsm_checker.sv
// Port-level checks of the clock source control
module icsm_checker (
  input wire logic CLOCK, // Clock
  input wire logic RESET_N, // Reset, active low
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB access
  input wire logic PWRITE, // APB direction
  input wire logic [11:0] PADDR, // APB address
  input wire logic [31:0] PWDATA, // APB write data
  input wire logic STOP_REQ, // Stop
  input wire icsm_pkg::icsm_osc_ctrl_t OSC_CTRL, // Oscillator controls
  input wire icsm_pkg::icsm_fll_ctrl_t FLL_CTRL, // FLL controls
  input wire logic INT_REF_ENABLE, // Internal reference on
  input wire logic AUX_EXT_CLK_EN, // Aux external clock
  input wire logic [1:0] OUT_SRC_SEL, // Applied source
  input wire logic [1:0] BUS_DIV_SEL, // Bus divider
  input wire logic BUS_CLK_EN // Bus clock enable
);
  import icsm_pkg::*;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  logic wr_c1;
  logic wr_c2;
  // Register writes at the access edge
  assign wr_c1 = PSEL && PENABLE && PWRITE && PADDR == 12'h000;
  assign wr_c2 = PSEL && PENABLE && PWRITE && PADDR == 12'h004;
  a_bus_div: assert property (wr_c2 |=> BUS_DIV_SEL == $past(PWDATA[7:6]))
    else $error("bus divider not taken");
  a_osc_fields: assert property (wr_c2 |=> OSC_CTRL.range_high == $past(PWDATA[5])
    && OSC_CTRL.high_gain == $past(PWDATA[4]) && OSC_CTRL.osc_request == $past(PWDATA[2]))
    else $error("oscillator controls wrong");
  a_aux_ext: assert property (wr_c2 && !STOP_REQ ##1 !STOP_REQ |-> AUX_EXT_CLK_EN == $past(PWDATA[1]))
    else $error("aux external clock wrong");
  a_src_internal: assert property (wr_c1 && PWDATA[7:6] == 2'h1 |-> ##2 OUT_SRC_SEL == 2'h1)
    else $error("internal source not applied");
  a_src_fll: assert property (wr_c1 && PWDATA[7] == PWDATA[6] && !STOP_REQ
    |-> ##2 OUT_SRC_SEL == 2'h0 && FLL_CTRL.enable) else $error("FLL source not applied");
  a_int_ref_on: assert property (FLL_CTRL.enable && FLL_CTRL.ref_internal && !STOP_REQ |-> INT_REF_ENABLE)
    else $error("internal reference off");
  a_ext_ref_on: assert property (FLL_CTRL.enable && !FLL_CTRL.ref_internal && !STOP_REQ |-> OSC_CTRL.enable)
    else $error("external reference off");
  a_fll_mult: assert property (FLL_CTRL.enable |-> FLL_CTRL.multiplier == 10'h200)
    else $error("FLL multiplier wrong");
  a_bus_pulse: assert property (BUS_CLK_EN && BUS_DIV_SEL == 2'h1 ##1 !STOP_REQ && $stable(BUS_DIV_SEL)
    |-> !BUS_CLK_EN) else $error("bus pulse too soon");
  c_int_mode: cover property (wr_c1 && PWDATA[7:6] == 2'h1);
  c_slow_bus: cover property (BUS_CLK_EN && BUS_DIV_SEL == 2'h3);
  c_stop_aux: cover property (STOP_REQ && AUX_EXT_CLK_EN);
endmodule : icsm_checker

bind icsm_top icsm_checker chk_i (.CLOCK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .STOP_REQ,
  .OSC_CTRL, .FLL_CTRL, .INT_REF_ENABLE, .AUX_EXT_CLK_EN, .OUT_SRC_SEL, .BUS_DIV_SEL, .BUS_CLK_EN);

// ### test/tb.sv
// Self-checking bench of the clock source control
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import icsm_pkg::*;
  logic CLOCK, RESET_N, PSEL, PENABLE, PWRITE, STOP_REQ, PREADY, PSLVERR;
  logic ok_init, ok_clk, err, INT_REF_ENABLE, AUX_EXT_CLK_EN, AUX_INT_CLK_EN, BUS_CLK_EN;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd, rnd;
  logic [8:0] INT_REF_TRIM;
  logic [1:0] OUT_SRC_SEL, BUS_DIV_SEL, src, es;
  icsm_osc_ctrl_t OSC_CTRL;
  icsm_fll_ctrl_t FLL_CTRL;
  int err_total, n_tests, pulses;
  icsm_top dut (.CLOCK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
    .STOP_REQ, .OSC_INIT_DONE(ok_init), .EXT_CLK_OK(ok_clk), .OSC_CTRL, .FLL_CTRL, .INT_REF_TRIM,
    .INT_REF_ENABLE, .AUX_INT_CLK_EN, .AUX_EXT_CLK_EN, .OUT_SRC_SEL, .BUS_DIV_SEL, .BUS_CLK_EN);
  icsm_osc_model osc (.osc_ctrl(OSC_CTRL), .init_done(ok_init), .clk_ok(ok_clk));
  // Clock, 40 ns period
  initial begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // APB transfer, held until pready is seen
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLOCK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // Let the write settle before anyone samples outputs
    @(negedge CLOCK);
  endtask : apb
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, {24'h0, exp}, rd);
  endtask : rdchk
  task automatic rst;
    @(posedge CLOCK);
    RESET_N <= 1'b0;
    repeat (20) @(posedge CLOCK);
    RESET_N <= 1'b1;
  endtask : rst
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  // Watchdog
  initial begin
    #(40 * 20000);
    err_total++;
    end_of_test;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {PSEL, PENABLE, PWRITE, STOP_REQ, RESET_N} = 5'h0;
    PADDR = 12'h0;
    PWDATA = 32'h0;
    rnd = 32'h56B372F7;
    rst;
    rdchk("ctrl1 reset", 12'h000, 8'h04);
    rdchk("ctrl2 reset", 12'h004, 8'h40);
    apb(1'b1, 12'h008, 32'hA5);
    apb(1'b1, 12'h00C, 32'h01);
    rst;
    rdchk("trim kept", 12'h008, 8'hA5);
    rdchk("status", 12'h00C, 8'h01);
    chk("trim code up", 32'h14B, {23'h0, INT_REF_TRIM});
    apb(1'b1, 12'h00C, 32'h00);
    chk("trim code down", 32'h14A, {23'h0, INT_REF_TRIM});
    repeat (8) begin
      rnd = lfsr(rnd);
      apb(1'b1, 12'h004, {24'h0, rnd[7:0]});
      rdchk("ctrl2", 12'h004, rnd[7:0]);
      chk("osc ctl", {26'h0, rnd[7:6], rnd[5:4], rnd[2:1]}, {26'h0, BUS_DIV_SEL, OSC_CTRL.range_high,
        OSC_CTRL.high_gain, OSC_CTRL.osc_request, AUX_EXT_CLK_EN});
    end
    for (int m = 0; m < 16; m++) begin
      src = m[3:2];
      es = (src == 2'h3) ? 2'h0 : src;
      apb(1'b1, 12'h004, {28'h0, m[0], 3'h6});
      apb(1'b1, 12'h000, {24'h0, src, 3'h3, m[1], 2'h0});
      repeat (40) @(posedge CLOCK);
      chk("source", {30'h0, es}, {30'h0, OUT_SRC_SEL});
      chk("fll on", {31'h0, es == 2'h0 || !m[0]}, {31'h0, FLL_CTRL.enable});
      chk("fll ref", {28'h0, m[1], 3'h3}, {28'h0, FLL_CTRL.ref_internal, FLL_CTRL.ref_div});
      rdchk("mode", 12'h00C, {4'h0, es, 2'h2});
    end
    apb(1'b1, 12'h004, 32'h02);
    rdchk("flag clear", 12'h00C, 8'h00);
    apb(1'b1, 12'h004, 32'h04);
    repeat (40) @(posedge CLOCK);
    rdchk("flag unused", 12'h00C, 8'h00);
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, 12'h004, {24'h0, d[1:0], 6'h03});
      repeat (8) @(posedge CLOCK);
      pulses = 0;
      repeat (64) begin
        @(negedge CLOCK);
        pulses += BUS_CLK_EN;
      end
      chk("bus pulses", 32'd64 >> d, pulses);
    end
    for (int s = 1; s >= 0; s--) begin
      apb(1'b1, 12'h000, {24'h0, 8'h1E | {7'h0, s[0]}});
      apb(1'b1, 12'h004, {31'h1, s[0]});
      @(posedge CLOCK) STOP_REQ <= 1'b1;
      repeat (4) @(negedge CLOCK);
      chk("stop aux", {31'h0, s[0]}, {31'h0, AUX_EXT_CLK_EN});
      chk("stop refs", {28'h0, {4{s[0]}}}, {28'h0, OSC_CTRL.enable, AUX_INT_CLK_EN, INT_REF_ENABLE, AUX_EXT_CLK_EN});
      chk("stop bus", 32'h0, {31'h0, BUS_CLK_EN});
      @(posedge CLOCK) STOP_REQ <= 1'b0;
    end
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err} | rd);
    end_of_test;
  end
endmodule : tb
